// [ispc_top.sv]
module ispc_top
    import ispc_pkg::*;
#(
    parameter int OST_CYCLES = OST_PERIODS,
    parameter int STAB_CYCLES = REG_STAB_CYC
) (
    input  wire logic       clock,           // system clock
    input  wire logic       rstn,            // async reset, active low
    input  wire logic [3:0] reg_addr,        // register address
    input  wire logic [7:0] reg_wdata,       // write data
    input  wire logic       reg_wr,          // write strobe
    input  wire logic       reg_rd,          // read strobe
    output logic      [7:0] reg_rdata,       // read data, cycle after strobe
    input  wire logic       sleep_exec,      // sleep instruction executes
    input  wire logic       irq_pending,     // enabled interrupt flag set
    input  wire logic       global_irq_enable, // core global enable
    input  wire logic       irq_entry,       // core enters service routine
    input  wire logic       irq_return,      // core returns from service routine
    input  wire logic       wdt_timeout,     // watchdog time-out
    input  wire logic       periph_osc_req,  // a peripheral requests osc [2:0] folded
    input  wire logic [2:0] osc_req,         // peripheral oscillator requests
    input  wire logic [7:0] port_periph_act, // per-port peripheral active
    output logic            core_clk_en,     // processor and memory enabled
    output logic            sys_clk_en,      // system (peripheral) clock enabled
    output logic            clock_output_pin_en,       // clock output pin drive enable
    output logic            wdt_clear,       // watchdog counter clear pulse
    output logic            wdt_run,         // watchdog may keep counting
    output logic            wdt_reset_block, // watchdog reset turned into wake, in idle only
    output logic            vector_jump,     // wake takes interrupt vector
    output logic            resume_next,     // wake resumes in-line
    output logic            regulator_lp,    // regulator in low-power state
    output logic      [2:0] osc_keep,        // fast, slow, secondary osc enables
    output logic            adc_abort,       // abort conversion, converter off
    output logic      [7:0] port_hold        // per-port drive state latched
);
    // ***********************************************
    // synchronised asynchronous inputs
    // ***********************************************
    logic [1:0] wdt_sync_reg;
    logic [3:0] req_s1_reg;
    logic [3:0] req_s2_reg;
    // watchdog time-out comes from the slow oscillator domain
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wdt_sync_reg <= 2'h0;
        end else begin
            wdt_sync_reg <= {wdt_sync_reg[0], wdt_timeout};
        end
    end

    // each request bit is synchronised alone, merged only after the second stage
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            req_s1_reg <= 4'h0;
            req_s2_reg <= 4'h0;
        end else begin
            req_s1_reg <= {periph_osc_req, osc_req};
            req_s2_reg <= req_s1_reg;
        end
    end
    wire wdt_evt = wdt_sync_reg[1];

    // ***********************************************
    // registers
    // ***********************************************
    logic [7:0]  regulator_reg;
    logic [7:0]  doze_idle_reg;
    logic [7:0]  status_reg;
    logic [7:0]  osc_en_reg;
    logic [7:0]  config_reg;
    ispc_state_t state_reg;
    ispc_state_t state_next;
    logic [10:0] delay_reg;
    logic        wake_irq;
    logic        wake_any;

    function automatic logic hit(input logic [3:0] a);
        hit = reg_wr && (reg_addr == a);
    endfunction

    function automatic logic asleep(input ispc_state_t s);
        asleep = (s == ISPC_SLEEP) || (s == ISPC_WAKE);
    endfunction

    // sleep entry only when no enabled interrupt is already pending
    wire sleep_go   = sleep_exec && !irq_pending && state_reg == ISPC_RUN;
    wire sleep_nop  = sleep_exec && irq_pending && state_reg == ISPC_RUN;
    wire go_full    = sleep_go && !doze_idle_reg[DI_IDLE_BIT];

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            regulator_reg <= REGULATOR_RESET;
            osc_en_reg    <= OSC_ENABLE_RESET;
            config_reg    <= CONFIG_RESET;
        end else begin
            if (hit(ADDR_REGULATOR)) begin
                regulator_reg <= (reg_wdata & 8'h02) | REGULATOR_RESET;
            end
            if (hit(ADDR_OSC_ENABLE)) begin
                osc_en_reg <= reg_wdata & 8'h07;
            end
            if (hit(ADDR_CONFIG)) begin
                config_reg <= reg_wdata & 8'h0F;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            doze_idle_reg <= DOZE_IDLE_RESET;
        end else begin
            if (hit(ADDR_DOZE_IDLE)) begin
                doze_idle_reg <= reg_wdata & DI_WMASK;
            end
            if ((irq_entry || (state_reg == ISPC_IDLE && irq_pending))
                && doze_idle_reg[DI_ROI_BIT]) begin
                doze_idle_reg[DI_SLOW_BIT] <= 1'b0;
            end else if (irq_return && doze_idle_reg[DI_DOE_BIT]) begin
                doze_idle_reg[DI_SLOW_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            status_reg <= STATUS_RESET;
        end else if (sleep_go) begin
            // flags update even if woken at once
            status_reg[ST_PD_BIT] <= 1'b0;
            status_reg[ST_TO_BIT] <= 1'b1;
        end else if (hit(ADDR_STATUS)) begin
            status_reg[ST_PD_BIT] <= reg_wdata[ST_PD_BIT];
            status_reg[ST_TO_BIT] <= reg_wdata[ST_TO_BIT];
        end
    end

    // ***********************************************
    // power state machine
    // ***********************************************
    always_comb begin
        // only watchdog or interrupt wake here; resets use rstn
        wake_irq = irq_pending;
        wake_any = irq_pending || (wdt_evt && (state_reg == ISPC_IDLE
                   || config_reg[CFG_WDT_SLP_BIT]));
        state_next = state_reg;
        case (state_reg)
            ISPC_RUN: begin
                if (sleep_go) begin
                    state_next = doze_idle_reg[DI_IDLE_BIT] ? ISPC_IDLE : ISPC_SLEEP;
                end
            end
            ISPC_IDLE: begin
                // any interrupt or watchdog ends idle
                if (wake_any) begin
                    state_next = ISPC_RUN;
                end
            end
            ISPC_SLEEP: begin
                if (wake_any) begin
                    state_next = ISPC_WAKE;
                end
            end
            ISPC_WAKE: begin
                if (delay_reg == 11'h000) begin
                    state_next = ISPC_RUN;
                end
            end
            default: state_next = ISPC_RUN;
        endcase
    end

    // state change on clock after instruction cycle
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_reg <= ISPC_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            delay_reg <= 11'h000;
        end else if (state_reg == ISPC_SLEEP && wake_any) begin
            delay_reg <= 11'((config_reg[CFG_CRYSTAL_BIT] ? OST_CYCLES : 0)
                       + (regulator_reg[REG_LP_BIT] ? STAB_CYCLES : 0));
        end else if (delay_reg != 11'h000) begin
            delay_reg <= delay_reg - 11'h001;
        end
    end

    // ***********************************************
    // outputs
    // ***********************************************
    // idle halts core only
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            core_clk_en <= 1'b1;
        end else begin
            core_clk_en <= state_next == ISPC_RUN;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sys_clk_en <= 1'b1;
        end else begin
            sys_clk_en <= !asleep(state_next);
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            clock_output_pin_en <= 1'b0;
        end else begin
            clock_output_pin_en <= config_reg[CFG_CLOCK_OUTPUT_PIN_BIT] && !asleep(state_next);
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            regulator_lp <= 1'b0;
        end else begin
            regulator_lp <= state_next == ISPC_SLEEP && regulator_reg[REG_LP_BIT];
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            osc_keep <= 3'h0;
        end else begin
            osc_keep <= req_s2_reg[2:0] | {3{req_s2_reg[3]}} | osc_en_reg[2:0];
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            adc_abort <= 1'b0;
        end else begin
            adc_abort <= (go_full || state_reg == ISPC_SLEEP)
                         && state_next == ISPC_SLEEP && !config_reg[CFG_ADC_RC_BIT];
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            port_hold <= 8'h00;
        end else begin
            port_hold <= (state_next == ISPC_SLEEP) ? ~port_periph_act : 8'h00;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wdt_reset_block <= 1'b0;
        end else begin
            wdt_reset_block <= state_next == ISPC_IDLE;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wdt_clear <= 1'b0;
            wdt_run   <= 1'b1;
        end else begin
            wdt_clear <= go_full || (state_reg == ISPC_SLEEP && wake_any);
            wdt_run   <= !(state_next == ISPC_SLEEP && !config_reg[CFG_WDT_SLP_BIT]);
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            vector_jump <= 1'b0;
            resume_next <= 1'b0;
        end else begin
            vector_jump <= state_reg != ISPC_RUN && state_next == ISPC_RUN
                           && wake_irq && global_irq_enable;
            resume_next <= (state_reg != ISPC_RUN && state_next == ISPC_RUN
                           && !(wake_irq && global_irq_enable)) || sleep_nop;
        end
    end

    // ***********************************************
    // read port
    // ***********************************************
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                ADDR_REGULATOR:  reg_rdata <= regulator_reg;
                ADDR_DOZE_IDLE:  reg_rdata <= doze_idle_reg;
                ADDR_STATUS:     reg_rdata <= status_reg;
                ADDR_OSC_ENABLE: reg_rdata <= osc_en_reg;
                ADDR_CONFIG:     reg_rdata <= config_reg;
                ADDR_STATE:      reg_rdata <= {6'h00, state_reg};
                default:         reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule

// [ispc_pkg.sv]
package ispc_pkg;
    // ***********************************************
    // register map
    // ***********************************************
    localparam logic [3:0] ADDR_REGULATOR  = 4'h0;
    localparam logic [3:0] ADDR_DOZE_IDLE  = 4'h1;
    localparam logic [3:0] ADDR_STATUS     = 4'h2;
    localparam logic [3:0] ADDR_OSC_ENABLE = 4'h3;
    localparam logic [3:0] ADDR_CONFIG     = 4'h4;
    localparam logic [3:0] ADDR_STATE      = 4'h5;

    // regulator_control fields
    localparam int         REG_LP_BIT       = 1;
    localparam int         REG_RSVD_BIT     = 0;
    localparam logic [7:0] REGULATOR_RESET  = 8'h01;
    // doze_idle_control fields
    localparam int         DI_IDLE_BIT      = 7;
    localparam int         DI_SLOW_BIT      = 6;
    localparam int         DI_ROI_BIT       = 5;
    localparam int         DI_DOE_BIT       = 4;
    localparam logic [7:0] DI_WMASK         = 8'hF7;
    localparam logic [7:0] DOZE_IDLE_RESET  = 8'h00;
    // status fields
    localparam int         ST_TO_BIT        = 4;
    localparam int         ST_PD_BIT        = 3;
    localparam logic [7:0] STATUS_RESET     = 8'h18;
    // oscillator enable fields
    localparam int         OSC_FAST_BIT     = 2;
    localparam int         OSC_SLOW_BIT     = 1;
    localparam int         OSC_SEC_BIT      = 0;
    localparam logic [7:0] OSC_ENABLE_RESET = 8'h00;
    // config fields
    localparam int         CFG_CRYSTAL_BIT  = 0;
    localparam int         CFG_CLOCK_OUTPUT_PIN_BIT   = 1;
    localparam int         CFG_ADC_RC_BIT   = 2;
    localparam int         CFG_WDT_SLP_BIT  = 3;
    localparam logic [7:0] CONFIG_RESET     = 8'h00;

    // ***********************************************
    // timing
    // ***********************************************
    localparam int          OST_PERIODS     = 1024;
    localparam int          REG_STAB_NS     = 10000;
    localparam int          CLK_NS          = 10;
    localparam int          REG_STAB_CYC    = (REG_STAB_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [1:0] {
        ISPC_RUN,
        ISPC_IDLE,
        ISPC_SLEEP,
        ISPC_WAKE
    } ispc_state_t;
endpackage

// [ispc_top_props.sv]
module ispc_top_props
    import ispc_pkg::*;
(
    input wire logic       clock,             // system clock
    input wire logic       rstn,              // async reset, active low
    input wire logic       reg_rd,            // read strobe
    input wire logic [7:0] reg_rdata,         // read data
    input wire logic       sleep_exec,        // sleep instruction
    input wire logic       irq_pending,       // enabled interrupt pending
    input wire logic       global_irq_enable, // core global enable
    input wire logic       core_clk_en,       // processor enabled
    input wire logic       sys_clk_en,        // system clock enabled
    input wire logic       wdt_clear,         // watchdog clear pulse
    input wire logic       vector_jump,       // wake to vector
    input wire logic       resume_next,       // wake in-line
    input wire logic       regulator_lp,      // regulator low power
    input wire logic       adc_abort,         // converter aborted
    input wire logic [7:0] port_hold          // ports latched
);
    // ****************************************
    // power-down checks
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    sequence s_sleep_go;
        sleep_exec && !irq_pending && core_clk_en;
    endsequence

    sequence s_full_sleep;
        !core_clk_en && !sys_clk_en;
    endsequence

    AST_SLEEP_HALTS: assert property (s_sleep_go |=> !core_clk_en)
        else $error("sleep did not halt the core");
    AST_NOP_RUNS: assert property (sleep_exec && irq_pending && core_clk_en
        |=> core_clk_en && !wdt_clear) else $error("pending sleep was not a no-op");
    AST_ENTRY_CLEAR: assert property ($fell(core_clk_en) && !sys_clk_en |-> wdt_clear)
        else $error("no watchdog clear on sleep entry");
    AST_WAKE_CLEAR: assert property (s_full_sleep ##0 $rose(irq_pending) |=> wdt_clear)
        else $error("no watchdog clear on wake");
    AST_VECTOR_GIE: assert property (vector_jump |-> $past(global_irq_enable) && !resume_next)
        else $error("vector taken without global enable");
    AST_CLEAR_PULSE: assert property (wdt_clear && !$fell(core_clk_en) |=> !wdt_clear)
        else $error("watchdog clear longer than one cycle");
    AST_LP_SLEEP: assert property (regulator_lp |-> s_full_sleep)
        else $error("regulator low power outside sleep");
    AST_RUN_FREE: assert property (core_clk_en && sys_clk_en
        |-> port_hold == 8'h00 && !adc_abort) else $error("ports held while running");
    AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
endmodule

bind ispc_top ispc_top_props i_props (.clock, .rstn, .reg_rd, .reg_rdata, .sleep_exec,
    .irq_pending, .global_irq_enable, .core_clk_en, .sys_clk_en, .wdt_clear, .vector_jump,
    .resume_next, .regulator_lp, .adc_abort, .port_hold);

// [ispc_top_bench.sv]
module ispc_top_bench
    import ispc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int OST_N  = 8;
    localparam int STAB_N = 4;
    logic       clock, rstn, reg_wr, reg_rd, sleep_exec, irq_pending, global_irq_enable;
    logic       irq_entry, irq_return, wdt_timeout, periph_osc_req, core_clk_en, sys_clk_en;
    logic       clock_output_pin_en, wdt_clear, wdt_run, wdt_reset_block, vector_jump, resume_next;
    logic       regulator_lp, adc_abort;
    logic [2:0] osc_req, osc_keep;
    logic [3:0] reg_addr, seen;
    logic [7:0] reg_wdata, reg_rdata, port_periph_act, port_hold;
    int         mismatches, n_tests, cycles, t_run;

    ispc_top #(.OST_CYCLES(OST_N), .STAB_CYCLES(STAB_N)) i_dut (.clock, .rstn, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sleep_exec, .irq_pending, .global_irq_enable,
        .irq_entry, .irq_return, .wdt_timeout, .periph_osc_req, .osc_req, .port_periph_act,
        .core_clk_en, .sys_clk_en, .clock_output_pin_en, .wdt_clear, .wdt_run, .wdt_reset_block,
        .vector_jump, .resume_next, .regulator_lp, .osc_keep, .adc_abort, .port_hold);

    // ****************************************
    // bus and observation tasks
    // ****************************************
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    task rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask

    task slp();
        @(posedge clock);
        sleep_exec <= 1'b1;
        @(posedge clock);
        sleep_exec <= 1'b0;
        #1;
    endtask

    // seen collects vector, resume, clear and reset-block pulses
    task watch(input int n);
        t_run = -1;
        seen = 4'h0;
        for (int i = 0; i < n; i++) begin
            @(posedge clock);
            #1;
            if (core_clk_en === 1'b1 && t_run < 0) t_run = i;
            seen |= {vector_jump, resume_next, wdt_clear, wdt_reset_block};
        end
    endtask

    task stop_test();
        $display("mismatches %0d tests %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task t_regs();
        rd(ADDR_REGULATOR, 8'h01);
        rd(ADDR_DOZE_IDLE, 8'h00);
        rd(4'hA, 8'h00);
        wr(ADDR_REGULATOR, 8'hFC);
        rd(ADDR_REGULATOR, 8'h01);
    endtask

    task t_sleep();
        wr(ADDR_CONFIG, 8'h0A);
        wr(ADDR_OSC_ENABLE, 8'h04);
        osc_req <= 3'b001;
        port_periph_act <= 8'h0F;
        global_irq_enable <= 1'b1;
        repeat (3) @(posedge clock);
        slp();
        chk(8'({core_clk_en, sys_clk_en, wdt_clear, wdt_run}), 8'h03);
        rd(ADDR_STATUS, 8'h10);
        chk(8'({regulator_lp, osc_keep, adc_abort}), 8'h0B);
        chk(port_hold, 8'hF0);
        @(posedge clock) irq_pending <= 1'b1;
        watch(30);
        @(posedge clock) irq_pending <= 1'b0;
        chk(8'({seen[3:1], t_run >= 0 && t_run < OST_N}), 8'h0B);
        rd(ADDR_STATUS, 8'h10);
    endtask

    task t_slow_wake();
        wr(ADDR_CONFIG, 8'h05);
        wr(ADDR_REGULATOR, 8'h03);
        global_irq_enable <= 1'b0;
        slp();
        chk(8'({regulator_lp, wdt_run, adc_abort}), 8'h04);
        @(posedge clock) irq_pending <= 1'b1;
        watch(40);
        @(posedge clock) irq_pending <= 1'b0;
        chk(8'({seen[3:2], t_run >= OST_N + STAB_N}), 8'h03);
    endtask

    task t_nop();
        wr(ADDR_REGULATOR, 8'h01);
        wr(ADDR_STATUS, 8'h18);
        irq_pending <= 1'b1;
        periph_osc_req <= 1'b1;
        slp();
        chk(8'({core_clk_en, wdt_clear}), 8'h02);
        @(posedge clock) irq_pending <= 1'b0;
        rd(ADDR_STATUS, 8'h18);
        chk(8'(osc_keep), 8'h07);
    endtask

    task t_idle();
        wr(ADDR_CONFIG, 8'h0A);
        wr(ADDR_DOZE_IDLE, 8'hE0);
        slp();
        chk(8'({core_clk_en, sys_clk_en, clock_output_pin_en}), 8'h03);
        @(posedge clock) irq_pending <= 1'b1;
        watch(10);
        @(posedge clock) irq_pending <= 1'b0;
        chk(8'(t_run >= 0), 8'h01);
        rd(ADDR_DOZE_IDLE, 8'hA0);
        wr(ADDR_DOZE_IDLE, 8'hE0);
        slp();
        @(posedge clock) wdt_timeout <= 1'b1;
        watch(10);
        @(posedge clock) wdt_timeout <= 1'b0;
        chk(8'({t_run >= 0, seen[0]}), 8'h03);
        rd(ADDR_DOZE_IDLE, 8'hE0);
        wr(ADDR_DOZE_IDLE, 8'h60);
        irq_entry <= 1'b1;
        @(posedge clock);
        irq_entry <= 1'b0;
        rd(ADDR_DOZE_IDLE, 8'h20);
        wr(ADDR_DOZE_IDLE, 8'h10);
        irq_return <= 1'b1;
        @(posedge clock);
        irq_return <= 1'b0;
        rd(ADDR_DOZE_IDLE, 8'h50);
    endtask

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            stop_test();
        end
    end

    initial begin
        {rstn, reg_wr, reg_rd, sleep_exec, irq_pending, global_irq_enable} = 6'h00;
        {irq_entry, irq_return, wdt_timeout, periph_osc_req} = 4'h0;
        {osc_req, reg_addr, reg_wdata, port_periph_act} = 23'h0;
        {mismatches, n_tests, cycles} = 0;
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        t_regs();
        t_sleep();
        t_slow_wake();
        t_nop();
        t_idle();
        stop_test();
    end
endmodule
